/* File: rtl/afc_pkg.sv */
// Constants, field layout and state type of the AM front-end configuration block.
// Assumes a single 40 MHz system clock; used by the top-level design file of the block and by the bench.
package afc_pkg;

	// ****************************************
	// Register layout
	// ****************************************
	localparam int CFG_W = 24;
	localparam logic [7:0] CFG_INDEX = 8'h00;
	localparam logic [23:0] CFG_RESET = 24'h00_0001;
	localparam int MIX_LSB = 0;
	localparam int MIX_MSB = 1;
	localparam int PIN_EXT_BIT = 12;
	localparam int AGC_PIN_ONLY_BIT = 13;
	localparam int TC_LSB = 14;
	localparam int TC_MSB = 15;
	localparam int THR_LSB = 16;
	localparam int THR_MSB = 18;
	localparam int ATTACK_BIT = 21;

	// ****************************************
	// Field encodings
	// ****************************************
	localparam logic [1:0] MIX_IN1 = 2'h1;
	localparam logic [1:0] MIX_IN2 = 2'h2;
	localparam logic [1:0] TC_SLOW = 2'h0;
	localparam logic [1:0] TC_MED = 2'h1;
	localparam logic [1:0] TC_UNDEF = 2'h2;
	localparam logic [1:0] TC_FAST = 2'h3;
	localparam int TC_SLOW_MS = 125;
	localparam int TC_MED_MS = 25;
	localparam int TC_FAST_MS = 5;
	localparam logic [6:0] THR_BASE_DBUV = 7'h5a;

	// ****************************************
	// Serial port and timing
	// ****************************************
	localparam logic BOOT_SPI = 1'b1;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [1:0] LAST_BYTE = 2'h2;
	localparam logic [5:0] PIN_IDLE = 6'h19;
	localparam int CLK_NS = 25;
	localparam int LATCH_NS = 10000;
	localparam logic [15:0] LATCH_CYC = 16'((LATCH_NS + CLK_NS - 1) / CLK_NS);

	typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_REG, ST_DATA, ST_IGNORE} afc_state_e;

endpackage

/* File: rtl/afc_pin_sync.sv */
// Three-stage synchroniser for a group of pins with agreement filter.
// Assumes the pins are asynchronous to clk; the output moves once stages two and three agree.
`timescale 1ns/1ps
module afc_pin_sync #(
	parameter int W = 6,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Pins and filtered result
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_out
);

	logic [W-1:0] ff1;
	logic [W-1:0] ff2;
	logic [W-1:0] ff3;
	logic [W-1:0] next_out;

	generate
		for (genvar i = 0; i < W; i++)
		begin : g_bit
			assign next_out[i] = (ff2[i] == ff3[i]) ? ff3[i] : pin_out[i];
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ff1 <= INIT;
			ff2 <= INIT;
			ff3 <= INIT;
			pin_out <= INIT;
		end
		else
		begin
			ff1 <= pin_in;
			ff2 <= ff1;
			ff3 <= ff2;
			pin_out <= next_out;
		end
	end

endmodule

/* File: rtl/afc_cfg_top.sv */
// AM front-end configuration register with its serial control port (I2C or SPI).
// Assumes boot_sel is held for the latch time after reset; all pins are asynchronous.
`timescale 1ns/1ps
// Notes on behaviour
// [R1] One 24-bit register at index zero
// [R2] Bits one-zero pick AM mixer input
// [R3] Two-bit AGC time constant, code 10 undefined
// [R4] Three-bit threshold maps to 87..93 dBuV
// [R5] Attack bit: normal cleared, fast set
// [R6] Host keeps undocumented bits at driver values
// [R7] PIN diode source and AGC mode bits
// [R8] Reached over I2C or SPI per boot
module afc_cfg_top #(
	parameter logic [6:0] DEV_ADDR = 7'h2a // Arbitrary bus address
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Boot strap
	input wire logic boot_sel,
	// I2C pins
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// SPI pins
	input wire logic sck,
	input wire logic mosi,
	input wire logic cs_n,
	output logic miso_out,
	output logic miso_oe,
	// Configuration outputs
	output logic [afc_pkg::CFG_W-1:0] cfg_word,
	output logic [1:0] mixer_sel,
	output logic pin_external,
	output logic agc_pin_only,
	output logic [1:0] agc_tc,
	output logic agc_tc_undefined,
	output logic [6:0] agc_thr_dbuv,
	output logic agc_fast_attack,
	output logic bus_mode_spi,
	output logic boot_done
);
	import afc_pkg::*;

	// ****************************************
	// Pin filtering and boot latch
	// ****************************************
	logic [5:0] pins_f;
	logic boot_f, scl_f, sda_f, sck_f, mosi_f, cs_n_f;
	logic [15:0] latch_cnt, next_latch_cnt;
	logic next_boot_done, next_mode_spi;

	afc_pin_sync #(.W(6), .INIT(PIN_IDLE)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_in({boot_sel, scl, sda_in, sck, mosi, cs_n}),
		.pin_out(pins_f)
	);
	assign {boot_f, scl_f, sda_f, sck_f, mosi_f, cs_n_f} = pins_f;

	always_comb
	begin
		next_latch_cnt = latch_cnt;
		next_boot_done = boot_done;
		next_mode_spi = bus_mode_spi;
		if (!boot_done)
		begin
			if (latch_cnt == LATCH_CYC)
			begin
				next_boot_done = 1'b1;
				next_mode_spi = (boot_f == BOOT_SPI); // R8
			end
			else
				next_latch_cnt = 16'(latch_cnt + 16'h0001);
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			latch_cnt <= 16'h0000;
			boot_done <= 1'b0;
			bus_mode_spi <= 1'b0;
		end
		else
		begin
			latch_cnt <= next_latch_cnt;
			boot_done <= next_boot_done;
			bus_mode_spi <= next_mode_spi;
		end
	end

	// ****************************************
	// Serial engine
	// ****************************************
	afc_state_e st, next_st;
	logic [3:0] bitcnt, next_bitcnt;
	logic [7:0] shreg, next_shreg, ptr, next_ptr, byte_in;
	logic [15:0] acc, next_acc;
	logic [23:0] tx, next_tx, wr_word, next_cfg;
	logic [1:0] byte_n, next_byte_n;
	logic rd, next_rd, ack, next_ack, sda_low, next_sda_low, next_miso;
	logic clk_prev, sda_prev, cs_prev, next_clk_prev, next_sda_prev, next_cs_prev;
	logic bus_clk, din, rise, fall, active, commit;

	function automatic logic [23:0] read_word(input logic [7:0] p, input logic [23:0] c);
		return (p == CFG_INDEX) ? c : 24'h00_0000;
	endfunction

	assign bus_clk = bus_mode_spi ? sck_f : scl_f;
	assign din = bus_mode_spi ? mosi_f : sda_f;
	assign rise = boot_done && bus_clk && !clk_prev;
	assign fall = boot_done && !bus_clk && clk_prev;
	assign active = (st == ST_DEV) || (st == ST_REG) || (st == ST_DATA);
	assign byte_in = {shreg[6:0], din};
	assign wr_word = {acc, byte_in};

	always_comb
	begin
		next_st = st;
		next_bitcnt = bitcnt;
		next_shreg = shreg;
		next_ptr = ptr;
		next_acc = acc;
		next_tx = tx;
		next_byte_n = byte_n;
		next_rd = rd;
		next_ack = ack;
		next_sda_low = sda_low;
		next_miso = miso_out;
		next_clk_prev = boot_done ? bus_clk : clk_prev;
		next_sda_prev = sda_f;
		next_cs_prev = cs_n_f;
		commit = 1'b0;
		if (!boot_done)
			next_st = ST_IDLE;
		else if (!bus_mode_spi && scl_f && sda_prev && !sda_f)
		begin
			next_st = ST_DEV; // R8
			next_bitcnt = 4'h0;
			next_rd = 1'b0;
			next_byte_n = 2'h0;
			next_sda_low = 1'b0;
		end
		else if (!bus_mode_spi && scl_f && !sda_prev && sda_f)
		begin
			next_st = ST_IDLE;
			next_sda_low = 1'b0;
		end
		else if (bus_mode_spi && cs_n_f)
			next_st = ST_IDLE;
		else if (bus_mode_spi && cs_prev)
		begin
			next_st = ST_REG; // R8
			next_bitcnt = 4'h0;
			next_rd = 1'b0;
			next_byte_n = 2'h0;
		end
		else if (rise && active)
		begin
			if (bitcnt == BYTE_BITS)
			begin
				next_bitcnt = 4'h0;
				if (rd && din)
					next_st = ST_IGNORE;
			end
			else
			begin
				next_shreg = byte_in;
				if (rd && st == ST_DATA)
					next_tx = {tx[22:0], 1'b0};
				if (bitcnt == LAST_BIT)
				begin
					next_bitcnt = bus_mode_spi ? 4'h0 : BYTE_BITS;
					next_ack = 1'b0;
					case (st)
						ST_DEV:
						begin
							if (byte_in[7:1] == DEV_ADDR)
							begin
								next_ack = 1'b1;
								next_rd = byte_in[0];
								next_st = byte_in[0] ? ST_DATA : ST_REG;
								next_tx = read_word(ptr, cfg_word);
								next_byte_n = 2'h0;
							end
							else
								next_st = ST_IGNORE;
						end
						ST_REG:
						begin
							next_ptr = bus_mode_spi ? {1'b0, byte_in[6:0]} : byte_in;
							next_rd = bus_mode_spi && byte_in[7];
							next_tx = read_word(next_ptr, cfg_word);
							next_ack = 1'b1;
							next_st = ST_DATA;
							next_byte_n = 2'h0;
						end
						ST_DATA:
						begin
							next_byte_n = (byte_n == LAST_BYTE) ? 2'h0 : 2'(byte_n + 2'h1);
							if (!rd)
							begin
								next_acc = wr_word[15:0];
								next_ack = 1'b1;
								commit = (byte_n == LAST_BYTE) && (ptr == CFG_INDEX); // R1
							end
						end
						default:
							next_st = ST_IGNORE;
					endcase
				end
				else
					next_bitcnt = 4'(bitcnt + 4'h1);
			end
		end
		if (fall && !bus_mode_spi)
			next_sda_low = active && ((bitcnt == BYTE_BITS) ? ack : (rd && st == ST_DATA && !tx[23]));
		if (fall && bus_mode_spi)
			next_miso = tx[23];
	end

	assign next_cfg = commit ? wr_word : cfg_word; // R1

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st <= ST_IDLE;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			ptr <= 8'h00;
			acc <= 16'h0000;
			tx <= 24'h00_0000;
			byte_n <= 2'h0;
			rd <= 1'b0;
			ack <= 1'b0;
			sda_low <= 1'b0;
			miso_out <= 1'b0;
			clk_prev <= 1'b0;
			sda_prev <= 1'b1;
			cs_prev <= 1'b1;
			cfg_word <= CFG_RESET;
		end
		else
		begin
			st <= next_st;
			bitcnt <= next_bitcnt;
			shreg <= next_shreg;
			ptr <= next_ptr;
			acc <= next_acc;
			tx <= next_tx;
			byte_n <= next_byte_n;
			rd <= next_rd;
			ack <= next_ack;
			sda_low <= next_sda_low;
			miso_out <= next_miso;
			clk_prev <= next_clk_prev;
			sda_prev <= next_sda_prev;
			cs_prev <= next_cs_prev;
			cfg_word <= next_cfg;
		end
	end

	// ****************************************
	// Pin drive and field decode
	// ****************************************
	function automatic logic [6:0] thr_dbuv(input logic [2:0] c);
		return c[2] ? 7'(THR_BASE_DBUV - {5'h00, c[1:0]}) : 7'(THR_BASE_DBUV + {5'h00, c[1:0]});
	endfunction

	assign sda_out = 1'b0;
	assign sda_oe = sda_low && !bus_mode_spi; // R8
	assign miso_oe = boot_done && bus_mode_spi && !cs_n_f; // R8
	assign mixer_sel = cfg_word[MIX_MSB:MIX_LSB]; // R2
	assign pin_external = cfg_word[PIN_EXT_BIT]; // R7
	assign agc_pin_only = cfg_word[AGC_PIN_ONLY_BIT]; // R7
	assign agc_tc = cfg_word[TC_MSB:TC_LSB]; // R3
	assign agc_tc_undefined = (agc_tc == TC_UNDEF); // R3
	assign agc_thr_dbuv = thr_dbuv(cfg_word[THR_MSB:THR_LSB]); // R4
	assign agc_fast_attack = cfg_word[ATTACK_BIT]; // R5

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_cs_high;
		cs_n_f [*2];
	endsequence

	sequence s_last_byte;
		rise && st == ST_DATA && !rd && bitcnt == LAST_BIT && byte_n == LAST_BYTE && ptr == CFG_INDEX;
	endsequence

	reg_hold_a: assert property (@(posedge clk) disable iff (sys_rst) !commit |=> $stable(cfg_word)) // R1
		else $error("config word changed without a write");
	reg_write_a: assert property (@(posedge clk) disable iff (sys_rst) s_last_byte |=> cfg_word == $past(wr_word)) // R8
		else $error("third data byte did not load config word");
	mixer_field_a: assert property (@(posedge clk) disable iff (sys_rst) mixer_sel == cfg_word[1:0]) // R2
		else $error("mixer select not from low bits");
	tc_undef_a: assert property (@(posedge clk) disable iff (sys_rst)
		agc_tc_undefined == (cfg_word[15] && !cfg_word[14])) // R3
		else $error("time constant undefined flag wrong");
	thr_low_a: assert property (@(posedge clk) disable iff (sys_rst)
		!cfg_word[18] |-> agc_thr_dbuv == 7'(7'd90 + cfg_word[17:16])) // R4
		else $error("threshold lower half mapping wrong");
	thr_high_a: assert property (@(posedge clk) disable iff (sys_rst)
		cfg_word[18] |-> agc_thr_dbuv == 7'(7'd90 - cfg_word[17:16])) // R4
		else $error("threshold upper half mapping wrong");
	attack_bit_a: assert property (@(posedge clk) disable iff (sys_rst) agc_fast_attack == cfg_word[21]) // R5
		else $error("attack bit not bit 21");
	pin_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
		pin_external == cfg_word[12] && agc_pin_only == cfg_word[13]) // R7
		else $error("PIN diode bits misplaced");
	miso_release_a: assert property (@(posedge clk) disable iff (sys_rst) s_cs_high |-> !miso_oe) // R8
		else $error("MISO driven while deselected");
	mode_excl_a: assert property (@(posedge clk) disable iff (sys_rst) bus_mode_spi |-> !sda_oe ##1 !sda_oe) // R8
		else $error("SDA driven in SPI mode");

endmodule

/* File: dv/am_frontend_config_register_tb.sv */
// Self-checking bench for the AM front-end configuration register and its serial port.
// Assumes afc_pkg and afc_cfg_top are compiled first; the bench drives every pin itself.
`timescale 1ns/1ps
module am_frontend_config_register_tb;
	import afc_pkg::*;
	localparam logic [6:0] I2C_ADDR = 7'h2a;
	// Bits with a user function; all others keep the value the driver last wrote
	localparam logic [23:0] DOC_MASK = 24'h27_f003;
	logic clk, sys_rst, boot_sel, scl, sda_drv, sck, mosi, cs_n;
	logic sda_out, sda_oe, miso_out, miso_oe, pin_external, agc_pin_only, agc_tc_undefined;
	logic agc_fast_attack, bus_mode_spi, boot_done;
	logic [1:0] mixer_sel, agc_tc;
	logic [6:0] agc_thr_dbuv;
	logic [23:0] cfg_word, cur, prev, w, rx;
	logic [23:0] exp_q[$];
	int err_count = 0;
	int num_checks = 0;
	int cycles = 0;
	int seed = 32'hfb7b_4353;
	// Open-drain data line: low whenever either side pulls
	wire sda_in = sda_drv & (sda_oe !== 1'b1);

	afc_cfg_top #(.DEV_ADDR(I2C_ADDR)) i_dut (.clk(clk), .sys_rst(sys_rst), .boot_sel(boot_sel),
		.scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .sck(sck), .mosi(mosi),
		.cs_n(cs_n), .miso_out(miso_out), .miso_oe(miso_oe), .cfg_word(cfg_word), .mixer_sel(mixer_sel),
		.pin_external(pin_external), .agc_pin_only(agc_pin_only), .agc_tc(agc_tc),
		.agc_tc_undefined(agc_tc_undefined), .agc_thr_dbuv(agc_thr_dbuv),
		.agc_fast_attack(agc_fast_attack), .bus_mode_spi(bus_mode_spi), .boot_done(boot_done));

	initial
	begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end

	// ****************************************
	// Compare and helper tasks
	// ****************************************
	task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_word({23'h0, got}, {23'h0, exp});
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic conclude();
		err_count += exp_q.size();
		$display("Checks %0d, errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic do_reset(input logic mode);
		sys_rst = 1;
		boot_sel = mode;
		scl = 1;
		sda_drv = 1;
		cs_n = 1;
		sck = 0;
		mosi = 0;
		cur = CFG_RESET;
		tick(16);
		chk_word(cfg_word, CFG_RESET);
		chk_bit(boot_done, 1'b0);
		sys_rst = 0;
		tick(420);
		chk_bit(boot_done, 1'b1);
		chk_bit(bus_mode_spi, mode);
	endtask

	// ****************************************
	// Serial port drivers
	// ****************************************
	task automatic spi_xfer(input logic [31:0] tx, input int nbits, output logic [23:0] got);
		got = '0;
		cs_n = 0;
		tick(8);
		chk_bit(miso_oe, 1'b1);
		for (int i = 0; i < nbits; i++)
		begin
			mosi = tx[31-i];
			tick(8);
			sck = 1;
			tick(8);
			if (i >= 8)
				got = {got[22:0], miso_out};
			sck = 0;
		end
		tick(8);
		cs_n = 1;
		tick(8);
	endtask

	task automatic spi_write(input logic [6:0] idx, input logic [23:0] d, input int nbits);
		logic [23:0] unused;
		if (idx == 7'h00 && nbits == 32)
		begin
			exp_q.push_back(d);
			cur = d;
		end
		spi_xfer({1'b0, idx, d}, nbits, unused);
		chk_word(cfg_word, cur);
	endtask

	task automatic i2c_byte(input logic [7:0] b, input logic ack);
		for (int i = 0; i < 9; i++)
		begin
			sda_drv = (i < 8) ? b[7-i] : 1'b1;
			tick(8);
			scl = 1;
			tick(8);
			if (i == 8)
			begin
				chk_bit(sda_oe, ack);
				chk_bit(sda_out, 1'b0);
			end
			scl = 0;
			tick(8);
		end
	endtask

	task automatic i2c_write(input logic [6:0] addr, input logic [23:0] d, input logic ok);
		if (ok)
		begin
			exp_q.push_back(d);
			cur = d;
		end
		sda_drv = 0;
		tick(8);
		scl = 0;
		tick(8);
		i2c_byte({addr, 1'b0}, ok);
		i2c_byte(8'h00, ok);
		for (int k = 2; k >= 0; k--)
			i2c_byte(d[8*k +: 8], ok);
		sda_drv = 0;
		tick(8);
		scl = 1;
		tick(8);
		sda_drv = 1;
		tick(8);
		chk_word(cfg_word, cur);
	endtask

	// ****************************************
	// Watcher: each register update takes the oldest expected word
	// ****************************************
	always @(posedge clk)
	begin
		cycles++;
		if (!sys_rst && cfg_word !== prev)
		begin
			if (exp_q.size() == 0)
				chk_word(cfg_word, prev);
			else
			begin
				w = exp_q.pop_front();
				chk_word(cfg_word, w);
				chk_word(24'(mixer_sel), 24'(w[1:0]));
				chk_bit(pin_external, w[PIN_EXT_BIT]);
				chk_bit(agc_pin_only, w[AGC_PIN_ONLY_BIT]);
				chk_word(24'(agc_tc), 24'(w[15:14]));
				chk_bit(agc_tc_undefined, w[15:14] == 2'b10);
				chk_word(24'(agc_thr_dbuv), 24'(w[18] ? THR_BASE_DBUV - 7'(w[17:16])
					: THR_BASE_DBUV + 7'(w[17:16])));
				chk_bit(agc_fast_attack, w[ATTACK_BIT]);
			end
		end
		prev <= cfg_word;
		if (cycles > 20000)
		begin
			err_count++;
			conclude();
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		do_reset(1'b1);
		for (int i = 0; i < 8; i++)
		begin
			rx = (24'($random(seed)) & DOC_MASK) | (cur & ~DOC_MASK);
			rx[1:0] = i[0] ? MIX_IN2 : MIX_IN1;
			rx[15:14] = i[1:0];
			rx[18:16] = i[2:0];
			rx[ATTACK_BIT] = ~cur[ATTACK_BIT];
			spi_write(7'h00, rx, 32);
			spi_xfer({1'b1, 7'h00, 24'h0}, 32, rx);
			chk_word(rx, cur);
		end
		spi_write(7'h05, 24'($random(seed)), 32);
		spi_xfer({1'b1, 7'h05, 24'h0}, 32, rx);
		chk_word(rx, 24'h0);
		spi_write(7'h00, ~cur, 24);
		do_reset(1'b0);
		rx = (24'($random(seed)) & DOC_MASK) | (cur & ~DOC_MASK);
		rx[1:0] = MIX_IN2;
		i2c_write(I2C_ADDR, rx, 1'b1);
		i2c_write(I2C_ADDR ^ 7'h01, ~cur, 1'b0);
		conclude();
	end
endmodule
